// file: common/fecc_pkg.sv
// Shared types and constants for the flash erase command host
package fecc_pkg;

  typedef enum logic [3:0] {
    OP_READ   = 4'h0, OP_RESET  = 4'h1, OP_PROG  = 4'h2, OP_SECT  = 4'h3,
    OP_ADD    = 4'h4, OP_CHIP   = 4'h5, OP_SUSP  = 4'h6, OP_RESUME = 4'h7,
    OP_BYPE   = 4'h8, OP_BYPP   = 4'h9, OP_BYPR  = 4'ha, OP_AUTO  = 4'hb,
    OP_QUERY  = 4'hc, OP_HWR    = 4'hd, OP_BAD_E = 4'he, OP_BAD_F = 4'hf
  } fecc_op_type;

  typedef enum logic [2:0] {
    MD_READ = 3'h0, MD_ACCUM = 3'h1, MD_ERASE = 3'h2, MD_SUSP = 3'h3,
    MD_CHIP = 3'h4, MD_BYP   = 3'h5, MD_AUTO  = 3'h6, MD_SPARE = 3'h7
  } fecc_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_SETUP = 4'h1, ST_WEL  = 4'h2, ST_HOLD  = 4'h3,
    ST_GAP  = 4'h4, ST_RDOE  = 4'h5, ST_RDWT = 4'h6, ST_WAIT  = 4'h7,
    ST_HWRST = 4'h8
  } fecc_state_type;

  typedef enum logic [1:0] {
    AK_UNL1 = 2'h0, AK_UNL2 = 2'h1, AK_QUERY = 2'h2, AK_USER = 2'h3
  } fecc_ak_type;

  // One write cycle of a command sequence
  typedef struct packed {
    fecc_ak_type ak;
    logic [7:0]  data;
  } fecc_wcyc_type;

  localparam logic [7:0]  D_UNL1 = 8'haa, D_UNL2 = 8'h55, D_SETUP = 8'h80;
  localparam logic [7:0]  D_SECT = 8'h30, D_CHIP = 8'h10, D_PROG = 8'ha0;
  localparam logic [7:0]  D_BYPE = 8'h20, D_AUTO = 8'h90, D_BYPX = 8'h00;
  localparam logic [7:0]  D_RESET = 8'hf0, D_SUSP = 8'hb0, D_RESUME = 8'h30;
  localparam logic [7:0]  D_QUERY = 8'h98;
  localparam logic [20:0] A_UNL1 = 21'h555, A_UNL2 = 21'h2aa, A_QUERY = 21'h55;

  // Word indexes on wb_adr_i[4:2]
  localparam logic [2:0] REG_CMD = 3'h0, REG_ADDR = 3'h1, REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam int ST_BUSY_BIT = 0, ST_ERR_BIT = 1, ST_RDY_BIT = 2, ST_WIN_BIT = 3;
  localparam int ST_MODE_LSB = 4, ST_RDATA_LSB = 8;

  localparam logic [20:0] ADDR_RST = 21'h0;
  localparam logic [7:0]  WDATA_RST = 8'h00;

  localparam int CLK_NS = 50;
  localparam int TWP_NS = 35;
  localparam int TWP_CYC = (TWP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TACC_NS = 90;
  localparam int TACC_CYC = (TACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3;
  localparam int ACC_WIN_US = 50;
  localparam int ACC_WIN_CYC = ACC_WIN_US * 1000 / CLK_NS;
  localparam int ACC_GUARD_US = 40;
  localparam int ACC_GUARD_CYC = ACC_GUARD_US * 1000 / CLK_NS;
  localparam int SUSP_US = 20;
  localparam int SUSP_CYC = (SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TRP_NS = 500;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;

endpackage

// file: hdl/fecc_host.sv
// Host controller driving a parallel flash through its command sequences
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module fecc_host
  import fecc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // Flash pins
  output logic      [20:0] flash_addr,
  output logic      [7:0]  dq_out,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_in,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic             reset_n,
  input  wire logic        ready_busy_output
);

  logic            ack_q, ack_d, err_q, err_d, auto_susp_q, auto_susp_d;
  logic            busy_seen_q, busy_seen_d, rdy_q, rdy_d;
  logic            dqoe_q, dqoe_d, ce_n_q, ce_n_d, we_n_q, we_n_d;
  logic            oe_n_q, oe_n_d, rst_n_q, rst_n_d;
  logic [31:0]     dat_q, dat_d;
  logic [20:0]     addr_q, addr_d, fa_q, fa_d;
  logic [7:0]      wdata_q, wdata_d, rdata_q, rdata_d, dqo_q, dqo_d;
  logic [7:0]      dq1_q, dq2_q, dq3_q;
  logic [2:0]      ry_s_q, idx_q, idx_d;
  logic [9:0]      tcnt_q, tcnt_d, acc_q, acc_d;
  fecc_state_type  st_q, st_d;
  fecc_op_type     op_q, op_d, new_op;
  fecc_mode_type   mode_q, mode_d;
  fecc_wcyc_type   ent;
  logic            bus_acc, cmd_wr, last;

  function automatic logic [2:0] seq_len(input fecc_op_type op);
    case (op)
      OP_PROG:                 seq_len = 3'd4;
      OP_SECT, OP_CHIP:        seq_len = 3'd6;
      OP_BYPE, OP_AUTO:        seq_len = 3'd3;
      OP_BYPP, OP_BYPR:        seq_len = 3'd2;
      OP_READ, OP_HWR:         seq_len = 3'd0;
      default:                 seq_len = 3'd1;
    endcase
  endfunction

  function automatic fecc_wcyc_type seq_ent(input fecc_op_type op, input logic [2:0] i,
                                            input logic [7:0] wd);
    seq_ent = '{AK_UNL1, D_UNL1};
    case (op)
      OP_RESET:  seq_ent = '{AK_USER, D_RESET};
      OP_ADD:    seq_ent = '{AK_USER, D_SECT};
      OP_SUSP:   seq_ent = '{AK_USER, D_SUSP};
      OP_RESUME: seq_ent = '{AK_USER, D_RESUME};
      OP_QUERY:  seq_ent = '{AK_QUERY, D_QUERY};
      OP_BYPP:   seq_ent = (i == 3'd0) ? '{AK_USER, D_PROG} : '{AK_USER, wd};
      OP_BYPR:   seq_ent = (i == 3'd0) ? '{AK_USER, D_AUTO} : '{AK_USER, D_BYPX};
      default: begin
        if (i == 3'd1 || i == 3'd4) begin
          seq_ent = '{AK_UNL2, D_UNL2};
        end else if (i == 3'd2) begin
          seq_ent.data = (op == OP_PROG) ? D_PROG :
                         (op == OP_BYPE) ? D_BYPE :
                         (op == OP_AUTO) ? D_AUTO : D_SETUP;
        end else if (i == 3'd3 && op == OP_PROG) begin
          seq_ent = '{AK_USER, wd};
        end else if (i == 3'd5) begin
          seq_ent = (op == OP_SECT) ? '{AK_USER, D_SECT} : '{AK_UNL1, D_CHIP};
        end
      end
    endcase
  endfunction

  // Refuse what the flash would ignore or misread in the current mode
  function automatic logic legal(input fecc_op_type op, input fecc_mode_type md,
                                 input logic [9:0] acc);
    case (md)
      MD_BYP:   legal = op inside {OP_BYPP, OP_BYPR, OP_READ, OP_HWR};
      MD_ERASE: legal = op inside {OP_SUSP, OP_READ, OP_HWR};
      MD_CHIP:  legal = op inside {OP_READ, OP_HWR};
      MD_ACCUM: legal = (op inside {OP_SUSP, OP_RESET, OP_READ, OP_HWR}) ||
                        (op == OP_ADD && acc < 10'(ACC_GUARD_CYC));
      MD_SUSP:  legal = op inside {OP_READ, OP_PROG, OP_AUTO, OP_RESUME,
                                   OP_RESET, OP_HWR};
      MD_AUTO:  legal = op inside {OP_READ, OP_RESET, OP_QUERY, OP_HWR};
      MD_READ:  legal = !(op inside {OP_ADD, OP_SUSP, OP_RESUME, OP_BYPP,
                                     OP_BYPR, OP_BAD_E, OP_BAD_F});
      default:  legal = 1'b0;
    endcase
  endfunction

  assign bus_acc = wb_cyc_i && wb_stb_i && ack_q;
  assign cmd_wr  = bus_acc && wb_we_i && wb_adr_i == REG_CMD && wb_sel_i[0];
  assign new_op  = fecc_op_type'(wb_dat_i[3:0]);
  assign ent     = seq_ent(op_q, idx_q, wdata_q);
  assign last    = idx_q == seq_len(op_q) - 3'd1;

  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    dat_d = 32'h0;
    err_d = err_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    st_d = st_q;
    op_d = op_q;
    idx_d = idx_q;
    tcnt_d = tcnt_q;
    mode_d = mode_q;
    acc_d = acc_q;
    auto_susp_d = auto_susp_q;
    busy_seen_d = busy_seen_q;
    rdy_d = (ry_s_q[1] == ry_s_q[2]) ? ry_s_q[2] : rdy_q;
    fa_d = fa_q;
    dqo_d = dqo_q;
    dqoe_d = dqoe_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    rst_n_d = rst_n_q;
    if (ack_d && !wb_we_i) begin
      case (wb_adr_i)
        REG_ADDR:  dat_d = {11'h0, addr_q};
        REG_WDATA: dat_d = {24'h0, wdata_q};
        REG_STAT: begin
          dat_d[ST_BUSY_BIT] = st_q != ST_IDLE;
          dat_d[ST_ERR_BIT] = err_q;
          dat_d[ST_RDY_BIT] = rdy_q;
          dat_d[ST_WIN_BIT] = mode_q == MD_ACCUM;
          dat_d[ST_MODE_LSB +: 3] = mode_q;
          dat_d[ST_RDATA_LSB +: 8] = rdata_q;
        end
        default:   dat_d = 32'h0;
      endcase
    end
    if (bus_acc && wb_we_i) begin
      if (wb_adr_i == REG_ADDR) begin
        if (wb_sel_i[0]) addr_d[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) addr_d[15:8] = wb_dat_i[15:8];
        if (wb_sel_i[2]) addr_d[20:16] = wb_dat_i[20:16];
      end
      if (wb_adr_i == REG_WDATA && wb_sel_i[0]) wdata_d = wb_dat_i[7:0];
      if (wb_adr_i == REG_STAT && wb_sel_i[0] && wb_dat_i[ST_ERR_BIT]) err_d = 1'b0;
    end
    // Background mode tracking
    if (mode_q == MD_ACCUM) begin
      if (acc_q >= 10'(ACC_WIN_CYC)) begin
        mode_d = MD_ERASE;
        busy_seen_d = 1'b0;
      end else begin
        acc_d = acc_q + 10'd1;
      end
    end
    if (mode_q == MD_ERASE || mode_q == MD_CHIP) begin
      if (!rdy_q) busy_seen_d = 1'b1;
      if (busy_seen_q && rdy_q) mode_d = MD_READ;
    end
    case (st_q)
      ST_IDLE: begin
        if (cmd_wr) begin
          if (!legal(new_op, mode_q, acc_q)) begin
            err_d = 1'b1;                                       // Set wins over clear
          end else begin
            op_d = new_op;
            idx_d = 3'd0;
            if (new_op == OP_HWR) begin
              rst_n_d = 1'b0;
              tcnt_d = 10'(TRP_CYC - 1);
              mode_d = MD_READ;
              auto_susp_d = 1'b0;
              st_d = ST_HWRST;
            end else begin
              st_d = (new_op == OP_READ) ? ST_RDOE : ST_SETUP;
            end
          end
        end
      end
      ST_SETUP: begin
        // Fixed command addresses leave the upper bits low
        case (ent.ak)
          AK_UNL1:  fa_d = A_UNL1;
          AK_UNL2:  fa_d = A_UNL2;
          AK_QUERY: fa_d = A_QUERY;
          default:  fa_d = addr_q;
        endcase
        dqo_d = ent.data;
        dqoe_d = 1'b1;
        ce_n_d = 1'b0;
        tcnt_d = 10'(TWP_CYC);
        st_d = ST_WEL;
      end
      ST_WEL: begin
        // Pins were set a cycle earlier and stay put across the pulse
        if (tcnt_q != 10'd0) begin
          we_n_d = 1'b0;
          tcnt_d = tcnt_q - 10'd1;
        end else begin
          we_n_d = 1'b1;
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        ce_n_d = 1'b1;
        st_d = ST_GAP;
        if (last) begin
          case (op_q)
            OP_SECT, OP_ADD: begin
              mode_d = MD_ACCUM;
              acc_d = 10'd0;
            end
            OP_CHIP: begin
              // A busy flag left over from the last erase would end this at once
              mode_d = MD_CHIP;
              busy_seen_d = 1'b0;
            end
            OP_SUSP: begin
              mode_d = MD_SUSP;
              if (mode_q == MD_ERASE) begin
                tcnt_d = 10'(SUSP_CYC - 1);
                st_d = ST_WAIT;
              end
            end
            OP_RESUME: begin
              mode_d = MD_ERASE;
              busy_seen_d = 1'b0;
            end
            OP_BYPE:   mode_d = MD_BYP;
            OP_BYPR:   mode_d = MD_READ;
            OP_AUTO: begin
              auto_susp_d = mode_q == MD_SUSP;
              mode_d = MD_AUTO;
            end
            OP_QUERY:  mode_d = MD_AUTO;
            OP_RESET: begin
              mode_d = (mode_q == MD_AUTO && auto_susp_q) ? MD_SUSP : MD_READ;
              auto_susp_d = 1'b0;
            end
            default:   mode_d = mode_q;
          endcase
        end
      end
      ST_GAP: begin
        dqoe_d = 1'b0;
        if (!last) begin
          idx_d = idx_q + 3'd1;
          st_d = ST_SETUP;
        end else begin
          st_d = (op_q == OP_AUTO) ? ST_RDOE : ST_IDLE;
        end
      end
      ST_RDOE: begin
        fa_d = addr_q;
        ce_n_d = 1'b0;
        oe_n_d = 1'b0;
        tcnt_d = 10'(TACC_CYC + SYNC_CYC - 1);
        st_d = ST_RDWT;
      end
      ST_RDWT: begin
        if (tcnt_q != 10'd0) begin
          tcnt_d = tcnt_q - 10'd1;
        end else if (dq2_q == dq3_q) begin
          rdata_d = dq3_q;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_WAIT: begin
        dqoe_d = 1'b0;
        if (tcnt_q != 10'd0) tcnt_d = tcnt_q - 10'd1;
        else st_d = ST_IDLE;
      end
      ST_HWRST: begin
        if (tcnt_q != 10'd0) tcnt_d = tcnt_q - 10'd1;
        else begin
          rst_n_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      err_q <= 1'b0;
      addr_q <= ADDR_RST;
      wdata_q <= WDATA_RST;
      rdata_q <= 8'h00;
      st_q <= ST_IDLE;
      op_q <= OP_READ;
      idx_q <= 3'd0;
      tcnt_q <= 10'd0;
      mode_q <= MD_READ;
      acc_q <= 10'd0;
      auto_susp_q <= 1'b0;
      busy_seen_q <= 1'b0;
      rdy_q <= 1'b1;
      ry_s_q <= 3'h7;
      dq1_q <= 8'h00;
      dq2_q <= 8'h00;
      dq3_q <= 8'h00;
      fa_q <= 21'h0;
      dqo_q <= 8'h00;
      dqoe_q <= 1'b0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      rst_n_q <= 1'b1;
    end else if (clk_en) begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      err_q <= err_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      op_q <= op_d;
      idx_q <= idx_d;
      tcnt_q <= tcnt_d;
      mode_q <= mode_d;
      acc_q <= acc_d;
      auto_susp_q <= auto_susp_d;
      busy_seen_q <= busy_seen_d;
      rdy_q <= rdy_d;
      ry_s_q <= {ry_s_q[1:0], ready_busy_output};
      dq1_q <= dq_in;
      dq2_q <= dq1_q;
      dq3_q <= dq2_q;
      fa_q <= fa_d;
      dqo_q <= dqo_d;
      dqoe_q <= dqoe_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      rst_n_q <= rst_n_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign flash_addr = fa_q;
  assign dq_out = dqo_q;
  assign dq_oe = dqoe_q;
  assign ce_n = ce_n_q;
  assign we_n = we_n_q;
  assign oe_n = oe_n_q;
  assign reset_n = rst_n_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !clk_en);

  a_sixth_sect_write: assert property ((st_q == ST_WEL && op_q == OP_SECT && idx_q == 3'd5)
    |-> dqo_q == D_SECT && fa_q == addr_q) else $error("sector erase final write wrong");
  a_window_restart: assert property ((st_q == ST_HOLD && last && op_q == OP_ADD)
    |=> mode_q == MD_ACCUM && acc_q == 10'd0) else $error("window not restarted");
  a_late_add_refused: assert property ((st_q == ST_IDLE && cmd_wr && new_op == OP_ADD
    && acc_q >= 10'(ACC_GUARD_CYC)) |=> err_q && st_q == ST_IDLE)
    else $error("late sector add accepted");
  a_window_expiry: assert property ((mode_q == MD_ACCUM && acc_q >= 10'(ACC_WIN_CYC)
    && st_q != ST_HOLD) |=> mode_q == MD_ERASE) else $error("window expiry missed");
  a_erase_only_susp: assert property ((mode_q == MD_ERASE && st_q == ST_SETUP)
    |-> op_q == OP_SUSP) else $error("write during erase not a suspend");
  a_chip_no_write: assert property (mode_q == MD_CHIP |-> st_q != ST_SETUP)
    else $error("write issued during chip erase");
  a_susp_wait: assert property ((st_q == ST_HOLD && op_q == OP_SUSP && mode_q == MD_ERASE)
    |=> st_q == ST_WAIT && tcnt_q == 10'(SUSP_CYC - 1)) else $error("suspend wait wrong");
  a_auto_to_susp: assert property ((st_q == ST_HOLD && op_q == OP_RESET && mode_q == MD_AUTO
    && auto_susp_q) |=> mode_q == MD_SUSP) else $error("autoselect exit lost suspend");
  a_strobe_stable: assert property (!we_n_q |=> we_n_q || ($stable(fa_q) && $stable(dqo_q)
    && dqoe_q)) else $error("pins moved under write strobe");
  a_data_after_rise: assert property ($rose(we_n_q) |-> dqoe_q && $stable(dqo_q))
    else $error("data dropped at strobe rise");
  a_hwrst_width: assert property ($fell(rst_n_q) |-> ##9 !rst_n_q ##1 rst_n_q)
    else $error("hardware reset pulse width wrong");

  c_erase_started: cover property (mode_q == MD_ACCUM ##1 mode_q == MD_ERASE);
  c_suspended: cover property (mode_q == MD_ERASE ##[1:1000] mode_q == MD_SUSP);
  c_bypass_prog: cover property (st_q == ST_HOLD && op_q == OP_BYPP && last);
  c_auto_read: cover property (st_q == ST_RDWT && op_q == OP_AUTO ##1 st_q == ST_IDLE);

endmodule // fecc_host

// file: verification/fecc_flash_model.sv
// Behavioural parallel flash that answers the host's command sequences
`timescale 1ns/1ps
module fecc_flash_model
  import fecc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hc3, // Arbitrary value
  parameter int         ERASE_US   = 150
)(
  // Host pins
  input  wire logic [20:0] flash_addr,
  input  wire logic [7:0]  dq_out,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        reset_n,
  // Device outputs
  output logic      [7:0]  dq_in,
  output logic             ready_busy_output
);
  fecc_mode_type md  = MD_READ;
  fecc_mode_type ret = MD_READ;
  logic [31:0]   mask = 32'h0;
  logic [20:0]   a_lat, pa;
  logic [7:0]    pd, rv;
  logic [7:0]    last = 8'h00;
  logic          wr = 1'b0;
  logic          tog = 1'b0;
  int            seq = 0;
  int            acc_us = 0;
  int            er_us = 0;

  task automatic cmd(input logic [20:0] a, input logic [7:0] d);
    logic [10:0] lo;
    lo = a[10:0];
    if (seq == 9) begin
      pa = a;
      pd = d;
      seq = 0;
      return;
    end
    case (md)
      MD_ACCUM: if (d == 8'h30) begin mask[a[20:16]] = 1'b1; acc_us = 0; end
        else if (d == 8'hb0) md = MD_SUSP;
        else begin md = MD_READ; mask = 32'h0; end
      MD_ERASE: if (d == 8'hb0) md = MD_SUSP;
      MD_CHIP: ;
      MD_BYP: if (seq == 7 && d == 8'h00) begin md = MD_READ; seq = 0; end
        else seq = (d == 8'ha0) ? 9 : (d == 8'h90) ? 7 : 0;
      MD_AUTO: if (d == 8'hf0) md = ret;
      default: if (d == 8'hf0) seq = 0;
        else if (seq == 0 && md == MD_SUSP && d == 8'h30) md = MD_ERASE;
        else if (seq == 0 && md == MD_READ && lo == 11'h055 && d == 8'h98) begin
          ret = md;
          md = MD_AUTO;
        end
        else if (seq == 0 && lo == 11'h555 && d == 8'haa) seq = 1;
        else if (seq == 1 && lo == 11'h2aa && d == 8'h55) seq = 2;
        else if (seq == 2 && lo == 11'h555) begin
          seq = (d == 8'h80 && md == MD_READ) ? 3 : (d == 8'ha0) ? 9 : 0;
          if (d == 8'h20 && md == MD_READ) md = MD_BYP;
          if (d == 8'h90) begin ret = md; md = MD_AUTO; end
        end
        else if (seq == 3 && lo == 11'h555 && d == 8'haa) seq = 4;
        else if (seq == 4 && lo == 11'h2aa && d == 8'h55) seq = 5;
        else if (seq == 5 && d == 8'h30) begin
          seq = 0;
          md = MD_ACCUM;
          mask[a[20:16]] = 1'b1;
          acc_us = 0;
          er_us = 0;
        end
        else if (seq == 5 && lo == 11'h555 && d == 8'h10) begin
          seq = 0;
          md = MD_CHIP;
          er_us = 0;
        end
        else seq = 0;
    endcase
  endtask

  // Address on the later fall, data on the earlier rise
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
    a_lat = flash_addr;
    wr = 1'b1;
  end
  always @(posedge we_n or posedge ce_n) if (wr) begin
    wr = 1'b0;
    cmd(a_lat, dq_out);
  end

  // Microsecond tick; erase time only runs while erasing, not while suspended
  always #1000 begin
    if (md == MD_ACCUM && ++acc_us >= 50) md = MD_ERASE;
    if ((md == MD_ERASE || md == MD_CHIP) && ++er_us >= ERASE_US) begin
      md = MD_READ;
      mask = 32'h0;
    end
  end

  always @(negedge reset_n) begin
    md = MD_READ;
    seq = 0;
    mask = 32'h0;
  end

  always_comb begin
    if (md == MD_AUTO)
      rv = (flash_addr[1:0] == 2'h0) ? MAKER_CODE :
           (flash_addr[1:0] == 2'h1) ? PART_CODE : 8'h00;
    else if (md != MD_READ && md != MD_BYP && (md != MD_SUSP || mask[flash_addr[20:16]]))
      rv = {md == MD_SUSP, tog, 2'h0, md != MD_ACCUM, tog, 2'h0};
    else
      rv = flash_addr[7:0] ^ 8'h5a;
  end
  always @(posedge oe_n) begin
    last = rv;
    tog = ~tog;
  end
  // Released bus shows the inverse so a stale value never reads as good
  assign dq_in = (!ce_n && !oe_n) ? rv : ~last;
  assign ready_busy_output = !(md == MD_ACCUM || md == MD_ERASE || md == MD_CHIP);
endmodule // fecc_flash_model

// file: verification/tb.sv
// Self-checking bench for the flash erase command host
`timescale 1ns/1ps
module tb
  import fecc_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] PART  = 8'hc3; // Arbitrary value
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [2:0]  adr = 3'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat, s, dat_o;
  logic        ack, dq_oe, ce_n, we_n, oe_n, reset_n, rdy;
  logic [20:0] fa, ra;
  logic [7:0]  dqo, dqi, rd;
  logic [4:0]  s1, s2;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 4;
  int          i;

  always #25 ref_clk = ~ref_clk;

  fecc_host u_fecc_host (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(dat_o), .flash_addr(fa), .dq_out(dqo), .dq_oe(dq_oe),
    .dq_in(dqi), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(reset_n),
    .ready_busy_output(rdy));
  fecc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_fecc_flash_model (
    .flash_addr(fa), .dq_out(dqo), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .reset_n(reset_n), .dq_in(dqi), .ready_busy_output(rdy));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Identity codes the model was built with, by read offset
  function automatic logic [31:0] exp_id(input int k);
    exp_id = (k == 0) ? 32'(MAKER) : (k == 1) ? 32'(PART) : 32'h0;
  endfunction

  task automatic wb(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic stat();
    wb(1'b0, REG_STAT, 32'h0);
    s = rdat;
  endtask

  task automatic cmd(input logic [3:0] op, input logic [20:0] a, input logic [7:0] d);
    wb(1'b1, REG_ADDR, {11'h0, a});
    wb(1'b1, REG_WDATA, {24'h0, d});
    wb(1'b1, REG_CMD, {28'h0, op});
    do stat(); while (s[ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic wait_mode(input logic [2:0] m);
    do stat(); while (s[ST_MODE_LSB +: 3] !== m);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Longest path is two full erases plus window waits
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    stat();
    check("status after reset", 32'(s[6:0]), 32'h4);
    wb(1'b0, 3'h5, 32'h0);
    check("unmapped read", rdat, 32'h0);
    s1 = 5'($random(seed));
    s2 = s1 ^ 5'h11;
    cmd(OP_SECT, {s1, 16'h0}, 8'h00);
    check("window open", 32'({s[ST_WIN_BIT], s[6:4]}), 32'({1'b1, MD_ACCUM}));
    cmd(OP_ADD, {s2, 16'h1234}, 8'h00);
    check("sector set", u_fecc_flash_model.mask, (32'h1 << s1) | (32'h1 << s2));
    wait_mode(MD_ERASE);
    check("erasing", 32'(u_fecc_flash_model.md), 32'(MD_ERASE));
    cmd(OP_SUSP, 21'h0, 8'h00);
    check("suspend", 32'({u_fecc_flash_model.md, s[6:4]}), 32'({MD_SUSP, MD_SUSP}));
    cmd(OP_AUTO, {s1, 16'h0}, 8'h00);
    for (i = 0; i < 3; i++) begin
      cmd(OP_READ, {s1, 14'h0, 2'(i)}, 8'h00);
      check("id code", 32'(s[15:8]), exp_id(i));
    end
    cmd(OP_RESET, 21'h0, 8'h00);
    check("back to suspend", 32'(u_fecc_flash_model.md), 32'(MD_SUSP));
    ra = {s1 ^ 5'h02, 16'($random(seed))};
    cmd(OP_READ, ra, 8'h00);
    check("other sector", 32'(s[15:8]), 32'(ra[7:0] ^ 8'h5a));
    cmd(OP_READ, {s2, 16'h0}, 8'h00);
    check("suspended status", 32'(s[15:8] & 8'hbb), 32'h88);
    cmd(OP_RESUME, 21'h0, 8'h00);
    cmd(OP_RESUME, 21'h0, 8'h00);
    check("resume", 32'(u_fecc_flash_model.md), 32'(MD_ERASE));
    wait_mode(MD_READ);
    check("erase done", u_fecc_flash_model.mask, 32'h0);
    wb(1'b1, REG_STAT, 32'h2);
    cmd(OP_CHIP, 21'h0, 8'h00);
    cmd(OP_SUSP, 21'h0, 8'h00);
    check("chip no suspend", 32'(s[ST_ERR_BIT]), 32'h1);
    check("chip still erasing", 32'(u_fecc_flash_model.md), 32'(MD_CHIP));
    wait_mode(MD_READ);
    repeat (3) begin
      ra = 21'($random(seed));
      rd = 8'($random(seed));
      cmd(OP_PROG, ra, rd);
      check("program address", 32'(u_fecc_flash_model.pa), 32'(ra));
      check("program data", 32'(u_fecc_flash_model.pd), 32'(rd));
    end
    cmd(OP_BYPE, 21'h0, 8'h00);
    check("bypass", 32'(u_fecc_flash_model.md), 32'(MD_BYP));
    ra = 21'($random(seed));
    rd = 8'($random(seed));
    cmd(OP_BYPP, ra, rd);
    check("bypass program address", 32'(u_fecc_flash_model.pa), 32'(ra));
    check("bypass program data", 32'(u_fecc_flash_model.pd), 32'(rd));
    cmd(OP_BYPR, 21'h0, 8'h00);
    check("bypass reset", 32'(u_fecc_flash_model.md), 32'(MD_READ));
    cmd(OP_QUERY, 21'h0, 8'h00);
    check("query", 32'(u_fecc_flash_model.md), 32'(MD_AUTO));
    cmd(OP_RESET, 21'h0, 8'h00);
    check("query exit", 32'(u_fecc_flash_model.md), 32'(MD_READ));
    cmd(OP_SECT, {s2, 16'h0}, 8'h00);
    cmd(OP_RESET, 21'h0, 8'h00);
    check("window abort", u_fecc_flash_model.mask, 32'h0);
    cmd(OP_SECT, {s1, 16'h0}, 8'h00);
    wb(1'b1, REG_STAT, 32'h2);
    // Past the add guard but still inside the window
    repeat (850) @(posedge ref_clk);
    cmd(OP_ADD, {s2, 16'h0}, 8'h00);
    check("late add refused", 32'(s[ST_ERR_BIT]), 32'h1);
    check("late add kept off", u_fecc_flash_model.mask, 32'h1 << s1);
    wait_mode(MD_ERASE);
    cmd(OP_HWR, 21'h0, 8'h00);
    check("hard reset", 32'(u_fecc_flash_model.md), 32'(MD_READ));
    tally_and_finish();
  end
endmodule // tb
